// [design/remote_upgrade_ctrl.sv]
// remote upgrade controller: control, staging, status and user watchdog
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - watchdog reload is timeout field above 17'b1000
// - boot address is field with two zero bits
// - 39-bit control and staging word layout
// - watchdog enable high, reserved bits fixed 0/1
// - early check: bad image or early done reloads factory
// - oscillator option selects internal startup clock
// - factory status: state, zeros, boot address
// - application word: state, enable, 29-bit timeout
// - one-hot sources, highest bit wins ties
// - records keep state and boot address
// - two records, newest first
// - early previous capture returns invalid marker
// - staging written by factory only; control by machine
// - fabric request copies staging, starts application load
// - error clears control; fabric loads staging
// - record written on the same edge the factory load starts
// - watchdog is 29-bit down counter from control
// - watchdog step is 2^17 counts
// - expiry reloads factory; flags watchdog unless a higher source wins the same cycle
// - watchdog counts only in application user mode
module remote_upgrade_ctrl #(
   parameter int DONE_MIN_CYC = upgrade_pkg::EARLY_DONE_CYC
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic upgrade_shift_clock,
   input wire logic shift_data_in,
   input wire logic shift_mode,
   input wire logic capture_not_update,
   input wire logic [1:0] read_select,
   output logic shift_data_out,
   input wire logic fabric_reconfig_request,
   input wire logic watchdog_reload_request,
   input wire logic external_reset_request,
   input wire logic crc_error_event,
   input wire logic config_error_pin_n,
   input wire logic config_complete_pin,
   input wire logic image_check_failed,
   output logic load_start,
   output logic load_factory,
   output logic [upgrade_pkg::BOOT_W-1:0] load_address,
   output logic startup_osc_select,
   output logic watchdog_timeout_flag,
   output logic [1:0] master_state,
   output logic app_user_mode
);
   import upgrade_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];

   // asserts at once, releases two edges later
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) rst_sync_ff <= 2'b00;
      else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   wire [PIN_W-1:0] pins = {image_check_failed, config_complete_pin, config_error_pin_n,
                            crc_error_event, external_reset_request, watchdog_reload_request,
                            fabric_reconfig_request, read_select, capture_not_update,
                            shift_mode, shift_data_in, upgrade_shift_clock};
   logic [PIN_W-1:0] meta_ff, s2_ff, s3_ff, filt_ff, filt_d_ff;

   // three stages; a level is taken only once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff[gi] <= PIN_IDLE[gi];
               s2_ff[gi] <= PIN_IDLE[gi];
               s3_ff[gi] <= PIN_IDLE[gi];
               filt_ff[gi] <= PIN_IDLE[gi];
               filt_d_ff[gi] <= PIN_IDLE[gi];
            end else begin
               meta_ff[gi] <= pins[gi];
               s2_ff[gi] <= meta_ff[gi];
               s3_ff[gi] <= s2_ff[gi];
               if (s2_ff[gi] == s3_ff[gi]) filt_ff[gi] <= s3_ff[gi];
               filt_d_ff[gi] <= filt_ff[gi];
            end
         end
      end
   endgenerate

   // all link pins share the same delay, so data lines up with the clock edge
   wire sck_rise = filt_ff[0] & ~filt_d_ff[0];
   wire s_din = filt_ff[1];
   wire s_shift = filt_ff[2];
   wire s_capture = filt_ff[3];
   wire [1:0] s_sel = filt_ff[5:4];
   wire fabric_rise = filt_ff[6] & ~filt_d_ff[6];
   wire reload_lvl = filt_ff[7];
   wire ext_rise = filt_ff[8] & ~filt_d_ff[8];
   wire crc_rise = filt_ff[9] & ~filt_d_ff[9];
   wire errpin_fall = ~filt_ff[10] & filt_d_ff[10];
   wire done_rise = filt_ff[11] & ~filt_d_ff[11];
   wire imgbad_rise = filt_ff[12] & ~filt_d_ff[12];

   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   master_state_t state_ff, nxt_state;
   logic [CTRL_W-1:0] control_ff, nxt_control;
   logic [CTRL_W-1:0] staging_ff;
   logic [CTRL_W-1:0] shreg_ff;
   logic [BOOT_W-1:0] boot_addr_ff, nxt_boot_addr;
   logic [STAT_W-1:0] prev1_ff, prev2_ff;
   logic app_seen_ff;
   logic [WD_W-1:0] wd_cnt_ff;
   logic [15:0] done_cnt_ff;
   logic load_start_ff, load_factory_ff, osc_sel_ff, wd_flag_ff;

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   wire in_factory = (state_ff == ST_FACTORY);
   wire in_cfg = (state_ff == ST_APP_CFG);
   wire in_user = (state_ff == ST_APP_USER);
   wire in_app = in_cfg | in_user;
   wire [TMO_W-1:0] ctl_tmo = control_ff[TMO_LSB +: TMO_W];
   wire [ADDR_W-1:0] ctl_addr = control_ff[ADDR_LSB +: ADDR_W];
   wire ctl_watchdog_enable_bit = control_ff[WATCHDOG_ENABLE_BIT_BIT]; // active high
   wire ctl_early = control_ff[EARLY_CHK_BIT];
   wire [WD_W-1:0] wd_reload = {ctl_tmo, WD_LOW_PATTERN};
   wire [ADDR_W-1:0] stg_addr = staging_ff[ADDR_LSB +: ADDR_W];
   wire [BOOT_W-1:0] stg_boot = {stg_addr, BOOT_LOW_BITS};
   wire [1:0] mode_code = in_factory ? MODE_FACTORY : MODE_APP;

   // ------------------------------------------------------------
   // reconfiguration sources
   // ------------------------------------------------------------
   // early check: image refused, or done arrives before the minimum time
   wire done_early = done_rise & (done_cnt_ff < 16'(DONE_MIN_CYC));
   wire cfg_fail = in_cfg & ctl_early & (imgbad_rise | done_early);
   wire wd_expire = in_user & ctl_watchdog_enable_bit & ~reload_lvl & (wd_cnt_ff == '0);
   wire [SRC_W-1:0] src_raw = {ext_rise, crc_rise & in_app, (errpin_fall & in_app) | cfg_fail,
                               wd_expire, fabric_rise & in_app};
   logic [SRC_W-1:0] src_hot;

   // ties resolve to the highest numbered source
   always_comb begin
      src_hot = '0;
      for (int i = SRC_W - 1; i >= 0; i--) begin
         if (src_raw[i] && src_hot == '0) src_hot[i] = 1'b1;
      end
   end

   wire app_exit = in_app & (src_raw != '0);
   wire factory_go = in_factory & fabric_rise & ~ext_rise;
   wire factory_reload = in_factory & ext_rise;
   wire cfg_done_ok = in_cfg & done_rise & ~app_exit;

   // ------------------------------------------------------------
   // master state machine
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_control = control_ff;
      nxt_boot_addr = boot_addr_ff;
      unique case (state_ff)
         ST_FACTORY: begin
            if (factory_go) begin
               nxt_control = staging_ff;
               nxt_boot_addr = stg_boot;
               nxt_state = ST_APP_CFG;
            end else if (factory_reload) begin
               nxt_control = CTRL_RESET;
               nxt_boot_addr = '0;
            end
         end
         ST_APP_CFG, ST_APP_USER: begin
            if (app_exit) begin
               nxt_control = CTRL_RESET;
               nxt_boot_addr = '0;
               nxt_state = ST_FACTORY;
            end else if (cfg_done_ok) begin
               nxt_state = ST_APP_USER;
            end
         end
      endcase
   end

   // state, control and boot address
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_FACTORY;
         control_ff <= CTRL_RESET;
         boot_addr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         control_ff <= nxt_control;
         boot_addr_ff <= nxt_boot_addr;
      end
   end

   // load pulse leaving an application starts on the same edge as the record write; other loads write no record
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         load_start_ff <= 1'b0;
         load_factory_ff <= 1'b1;
         osc_sel_ff <= 1'b0;
         wd_flag_ff <= 1'b0;
      end else begin
         load_start_ff <= factory_go | factory_reload | app_exit;
         if (factory_go | factory_reload | app_exit) load_factory_ff <= ~factory_go;
         osc_sel_ff <= (nxt_state == ST_APP_CFG) & nxt_control[OSC_SEL_BIT];
         wd_flag_ff <= wd_expire & (src_hot == 5'b00010);
      end
   end

   // ------------------------------------------------------------
   // previous-state records
   // ------------------------------------------------------------
   wire [STAT_W-1:0] prev_new = {1'b0, src_hot, mode_code, boot_addr_ff};

   // newest record shifts the older one down, written while leaving the image
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         prev1_ff <= '0;
         prev2_ff <= '0;
         app_seen_ff <= 1'b0;
      end else begin
         if (app_exit) begin
            prev1_ff <= prev_new;
            prev2_ff <= prev1_ff;
         end
         if (factory_go) app_seen_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // user watchdog
   // ------------------------------------------------------------
   // idle outside user mode so configuration time never counts against it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) wd_cnt_ff <= '0;
      else if (!in_user || reload_lvl) wd_cnt_ff <= wd_reload;
      else if (ctl_watchdog_enable_bit && wd_cnt_ff != '0) wd_cnt_ff <= wd_cnt_ff - 1'b1;
   end

   // time since the application load started, saturating
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) done_cnt_ff <= '0;
      else if (!in_cfg) done_cnt_ff <= '0;
      else if (done_cnt_ff != 16'hffff) done_cnt_ff <= done_cnt_ff + 1'b1;
   end

   // ------------------------------------------------------------
   // capture sources for the shift register
   // ------------------------------------------------------------
   wire [STAT_W-1:0] stat_factory = {mode_code, 6'h00, boot_addr_ff};
   wire [STAT_W-1:0] stat_app1 = {mode_code, ctl_watchdog_enable_bit, wd_reload};
   wire [STAT_W-1:0] stat_app2 = {mode_code, 6'h00, boot_addr_ff};
   wire [STAT_W-1:0] stat_cur = in_factory ? stat_factory : stat_app1;
   wire [STAT_W-1:0] p1_view = app_seen_ff ? prev1_ff : PREV_INVALID;
   wire [STAT_W-1:0] p2_view = app_seen_ff ? prev2_ff : PREV_INVALID;
   // factory reads back staging, an application reads its second word
   wire [CTRL_W-1:0] word_view = in_factory ? staging_ff : CTRL_W'(stat_app2);
   wire [CTRL_W-1:0] cap_val = (s_sel == SEL_CURRENT) ? CTRL_W'(stat_cur) :
                               (s_sel == SEL_PREV1) ? CTRL_W'(p1_view) :
                               (s_sel == SEL_PREV2) ? CTRL_W'(p2_view) : word_view;
   // staging image with reserved bits forced to their fixed values
   logic [CTRL_W-1:0] stg_write;
   always_comb begin
      stg_write = shreg_ff;
      stg_write[RSV_LO_BIT] = RSV_LO_VAL;
      stg_write[RSV_HI_BIT] = RSV_HI_VAL;
   end
   wire do_update = sck_rise & ~s_shift & ~s_capture & in_factory;

   // ------------------------------------------------------------
   // shift register and staging
   // ------------------------------------------------------------
   // lsb leaves first; everything moves only on a sampled link clock edge
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) shreg_ff <= '0;
      else if (sck_rise && s_shift) shreg_ff <= {s_din, shreg_ff[CTRL_W-1:1]};
      else if (sck_rise && s_capture) shreg_ff <= cap_val;
   end

   // applications cannot write staging; the update is silently dropped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) staging_ff <= CTRL_RESET;
      else if (do_update) staging_ff <= stg_write;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign shift_data_out = shreg_ff[0];
   assign load_start = load_start_ff;
   assign load_factory = load_factory_ff;
   assign load_address = boot_addr_ff;
   assign startup_osc_select = osc_sel_ff;
   assign watchdog_timeout_flag = wd_flag_ff;
   assign master_state = mode_code;
   assign app_user_mode = in_user;
endmodule

`default_nettype wire

// [design/upgrade_pkg.sv]
// constants shared by the remote upgrade controller
package upgrade_pkg;
   // ------------------------------------------------------------
   // control / staging word layout
   // ------------------------------------------------------------
   localparam int CTRL_W = 39;
   localparam int TMO_LSB = 0;
   localparam int TMO_W = 12;
   localparam int ADDR_LSB = 12;
   localparam int ADDR_W = 22;
   localparam int RSV_LO_BIT = 34;
   localparam int WATCHDOG_ENABLE_BIT_BIT = 35;
   localparam int OSC_SEL_BIT = 36;
   localparam int EARLY_CHK_BIT = 37;
   localparam int RSV_HI_BIT = 38;
   localparam logic RSV_LO_VAL = 1'b0;
   localparam logic RSV_HI_VAL = 1'b1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 39'h00_0000_0000;
   // ------------------------------------------------------------
   // watchdog and boot address forming
   // ------------------------------------------------------------
   localparam int WD_W = 29;
   localparam logic [16:0] WD_LOW_PATTERN = 17'b1000;
   localparam int BOOT_W = 24;
   localparam logic [1:0] BOOT_LOW_BITS = 2'b0;
   // ------------------------------------------------------------
   // status word layout
   // ------------------------------------------------------------
   localparam int STAT_W = 32;
   localparam int SRC_LSB = 26;
   localparam int SRC_W = 5;
   localparam logic [1:0] MODE_FACTORY = 2'b01;
   localparam logic [1:0] MODE_APP = 2'b10;
   localparam logic [STAT_W-1:0] PREV_INVALID = 32'hdead_0bad;
   // capture selector codes
   localparam logic [1:0] SEL_CURRENT = 2'h0;
   localparam logic [1:0] SEL_PREV1 = 2'h1;
   localparam logic [1:0] SEL_PREV2 = 2'h2;
   localparam logic [1:0] SEL_WORD = 2'h3;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int EARLY_DONE_MIN_NS = 1000;
   localparam int EARLY_DONE_CYC = (EARLY_DONE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
   // synchroniser resets: the error pin idles high
   localparam int PIN_W = 13;
   localparam logic [PIN_W-1:0] PIN_IDLE = 13'h0400;
   typedef enum logic [2:0] {
      ST_FACTORY = 3'b001,
      ST_APP_CFG = 3'b010,
      ST_APP_USER = 3'b100
   } master_state_t;
endpackage

// [testbench/upgrade_properties.sv]
// port-level assertions for the remote upgrade controller
`timescale 1ns/10ps
`default_nettype none
module upgrade_properties #(
   parameter int DONE_MIN_CYC = 4
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic fabric_reconfig_request,
   input wire logic watchdog_reload_request,
   input wire logic config_complete_pin,
   input wire logic load_start,
   input wire logic load_factory,
   input wire logic [upgrade_pkg::BOOT_W-1:0] load_address,
   input wire logic startup_osc_select,
   input wire logic watchdog_timeout_flag,
   input wire logic [1:0] master_state,
   input wire logic app_user_mode
);
   import upgrade_pkg::*;
   // ------------------------------------------------------------
   // load sequencing and watchdog
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // request must stay up long enough to pass the pin filter
   // the pin filter takes four edges, so the load shows up two edges after this ends
   sequence s_req_held; $rose(fabric_reconfig_request) ##1 fabric_reconfig_request [*3]; endsequence
   sequence s_reload_held; (app_user_mode && watchdog_reload_request) [*8]; endsequence
   property p_start_pulse; load_start |=> !load_start; endproperty
   property p_reconfig; s_req_held |-> ##[0:3] load_start; endproperty
   property p_addr_low; load_start |-> load_address[1:0] == BOOT_LOW_BITS; endproperty
   property p_factory_load; load_start && load_factory |-> !load_address && !startup_osc_select;
   endproperty
   property p_start_state; load_start |-> master_state == (load_factory ? MODE_FACTORY : MODE_APP);
   endproperty
   property p_mode_code; master_state == MODE_FACTORY || master_state == MODE_APP; endproperty
   property p_user_app; app_user_mode |-> master_state == MODE_APP; endproperty
   property p_complete;
      master_state == MODE_APP && !app_user_mode && $rose(config_complete_pin)
         |-> ##[3:8] app_user_mode;
   endproperty
   property p_reload; s_reload_held |=> !watchdog_timeout_flag; endproperty
   property p_not_user; !app_user_mode [*4] |-> !watchdog_timeout_flag; endproperty
   property p_flag; watchdog_timeout_flag |-> load_factory && master_state == MODE_FACTORY;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("load start too wide");
   a_reconfig: assert property (p_reconfig) else $error("reconfig gave no load");
   a_addr_low: assert property (p_addr_low) else $error("boot address low bits set");
   a_factory_load: assert property (p_factory_load) else $error("control not cleared");
   a_start_state: assert property (p_start_state) else $error("load kind vs state");
   a_mode_code: assert property (p_mode_code) else $error("bad master state code");
   a_user_app: assert property (p_user_app) else $error("user mode outside app");
   a_complete: assert property (p_complete) else $error("no user mode entry");
   a_reload: assert property (p_reload) else $error("expiry while reloaded");
   a_not_user: assert property (p_not_user) else $error("expiry outside user mode");
   a_flag: assert property (p_flag) else $error("expiry without factory load");
endmodule
bind remote_upgrade_ctrl upgrade_properties #(.DONE_MIN_CYC(DONE_MIN_CYC)) props (
   .clock(clock), .resetn(resetn), .fabric_reconfig_request(fabric_reconfig_request),
   .watchdog_reload_request(watchdog_reload_request), .config_complete_pin(config_complete_pin),
   .load_start(load_start), .load_factory(load_factory), .load_address(load_address),
   .startup_osc_select(startup_osc_select), .watchdog_timeout_flag(watchdog_timeout_flag),
   .master_state(master_state), .app_user_mode(app_user_mode));
`default_nettype wire

// [testbench/fabric_user_model.sv]
// user fabric model: drives the shift link and the reconfiguration request
`timescale 1ns/10ps
`default_nettype none
module fabric_user_model (
   input wire logic clock,
   input wire logic shift_data_out,
   output logic upgrade_shift_clock,
   output logic shift_data_in,
   output logic shift_mode,
   output logic capture_not_update,
   output logic [1:0] read_select,
   output logic fabric_reconfig_request
);
   // ------------------------------------------------------------
   // link access
   // ------------------------------------------------------------
   // link clock idles low between frames, 4 clocks low and 4 high
   initial begin
      upgrade_shift_clock = 1'b0;
      shift_data_in = 1'b0;
      shift_mode = 1'b0;
      capture_not_update = 1'b0;
      read_select = 2'h0;
      fabric_reconfig_request = 1'b0;
   end
   task automatic pulse;
      repeat (4) @(posedge clock);
      upgrade_shift_clock <= 1'b1;
      repeat (4) @(posedge clock);
      upgrade_shift_clock <= 1'b0;
   endtask
   // capture or update, chosen by cnu
   task automatic ctl(input logic cnu, input logic [1:0] sel);
      @(posedge clock);
      shift_mode <= 1'b0;
      capture_not_update <= cnu;
      read_select <= sel;
      pulse();
   endtask
   // lsb leaves first; new bits enter at the top
   task automatic word(input logic [38:0] w, output logic [38:0] r);
      for (int i = 0; i < 39; i++) begin
         @(posedge clock);
         shift_mode <= 1'b1;
         shift_data_in <= w[i];
         repeat (3) @(posedge clock);
         r[i] = shift_data_out;
         upgrade_shift_clock <= 1'b1;
         repeat (4) @(posedge clock);
         upgrade_shift_clock <= 1'b0;
      end
      // a released data line must not look like a held bit
      shift_data_in <= ~shift_data_in;
   endtask
   task automatic reconfig;
      @(posedge clock);
      fabric_reconfig_request <= 1'b1;
      repeat (64) @(posedge clock);
      fabric_reconfig_request <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [testbench/remote_upgrade_ctrl_test.sv]
// self-checking bench for the remote upgrade controller
`timescale 1ns/10ps
`default_nettype none
`define CHECK(n, e, g) cmp(n, 39'(e), 39'(g))
module remote_upgrade_ctrl_test;
   import upgrade_pkg::*;
   logic clock, resetn, usck, sdi, smode, cnu, reconf, reload, ext_rst, crc, err_n, done, bad;
   logic [1:0] rsel, master_state;
   logic sdo, load_start, load_factory, osc, flag, user;
   logic [23:0] load_address;
   logic [25:0] notes[$];
   logic [38:0] r, w1, w2;
   logic [21:0] a1, a2;
   logic [11:0] t1;
   integer seed = 83375;
   int n_errors = 0;
   int n_compared = 0;
   int n_flag = 0;
   remote_upgrade_ctrl #(.DONE_MIN_CYC(4)) dut (.clock(clock), .resetn(resetn),
      .upgrade_shift_clock(usck), .shift_data_in(sdi), .shift_mode(smode),
      .capture_not_update(cnu), .read_select(rsel), .shift_data_out(sdo),
      .fabric_reconfig_request(reconf), .watchdog_reload_request(reload),
      .external_reset_request(ext_rst), .crc_error_event(crc), .config_error_pin_n(err_n),
      .config_complete_pin(done), .image_check_failed(bad), .load_start(load_start),
      .load_factory(load_factory), .load_address(load_address), .startup_osc_select(osc),
      .watchdog_timeout_flag(flag), .master_state(master_state), .app_user_mode(user));
   fabric_user_model fab (.clock(clock), .shift_data_out(sdo), .upgrade_shift_clock(usck),
      .shift_data_in(sdi), .shift_mode(smode), .capture_not_update(cnu), .read_select(rsel),
      .fabric_reconfig_request(reconf));
   // ------------------------------------------------------------
   // clock, tasks and monitor
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic cmp(input string n, input logic [38:0] e, input logic [38:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [1:0] sel, output logic [38:0] v);
      fab.ctl(1'b1, sel);
      fab.word(39'h0, v);
   endtask
   task automatic wr(input logic [38:0] v);
      logic [38:0] d;
      fab.word(v, d);
      fab.ctl(1'b0, SEL_CURRENT);
   endtask
   // each load pulse takes the oldest note
   always @(posedge clock) begin
      if (load_start === 1'b1) begin
         `CHECK("load_queue", 1, notes.size() > 0);
         if (notes.size() > 0) `CHECK("load", notes.pop_front(), {load_factory, osc, load_address});
      end
      if (flag === 1'b1) n_flag++;
   end
   // whole run is about 5.3k clocks of the 50k allowed, so this leaves ample margin
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   initial begin
      {resetn, reload, ext_rst, crc, done, bad} = 6'h0;
      err_n = 1'b1;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      repeat (8) @(posedge clock);
      rd(SEL_CURRENT, r);
      `CHECK("status_factory", {MODE_FACTORY, 30'h0}, r);
      rd(SEL_PREV1, r);
      `CHECK("prev_early", PREV_INVALID, r);
      a1 = 22'($random(seed));
      t1 = 12'($random(seed));
      w1 = {1'b0, 1'b1, 1'b1, 1'b0, 1'b1, a1, t1};
      wr(w1);
      rd(SEL_WORD, r);
      `CHECK("staging", {1'b1, w1[37:35], 1'b0, w1[33:0]}, r);
      notes.push_back({2'b01, a1, BOOT_LOW_BITS});
      fab.reconfig();
      `CHECK("mode_app", MODE_APP, master_state);
      repeat (16) @(posedge clock);
      done <= 1'b1;
      repeat (12) @(posedge clock);
      `CHECK("user_mode", 1, user);
      rd(SEL_CURRENT, r);
      `CHECK("app_word1", {MODE_APP, 1'b0, t1, WD_LOW_PATTERN}, r);
      rd(SEL_WORD, r);
      `CHECK("app_word2", {MODE_APP, 6'h0, a1, BOOT_LOW_BITS}, r);
      // an update from the application must be ignored
      wr(~w1);
      notes.push_back({2'b10, 24'h0});
      fab.reconfig();
      done <= 1'b0;
      rd(SEL_PREV1, r);
      `CHECK("prev1_fabric", {1'b0, 5'b00001, MODE_APP, a1, BOOT_LOW_BITS}, r);
      rd(SEL_WORD, r);
      `CHECK("staging_kept", {1'b1, w1[37:35], 1'b0, w1[33:0]}, r);
      // shortest timeout: 8 counts once reloading stops
      a2 = 22'($random(seed));
      w2 = {4'hf, 1'b0, a2, 12'h0};
      wr(w2);
      notes.push_back({2'b01, a2, BOOT_LOW_BITS});
      fab.reconfig();
      reload <= 1'b1;
      repeat (16) @(posedge clock);
      done <= 1'b1;
      repeat (60) @(posedge clock);
      `CHECK("wd_reloaded", 1, user);
      notes.push_back({2'b10, 24'h0});
      reload <= 1'b0;
      repeat (40) @(posedge clock);
      `CHECK("wd_flag", 1, n_flag);
      done <= 1'b0;
      rd(SEL_PREV1, r);
      `CHECK("prev1_wd", {1'b0, 5'b00010, MODE_APP, a2, BOOT_LOW_BITS}, r);
      rd(SEL_PREV2, r);
      `CHECK("prev2", {1'b0, 5'b00001, MODE_APP, a1, BOOT_LOW_BITS}, r);
      rd(SEL_CURRENT, r);
      `CHECK("status_cleared", {MODE_FACTORY, 30'h0}, r);
      // a refused image while configuring counts as a status-pin error
      notes.push_back({2'b01, a2, BOOT_LOW_BITS});
      notes.push_back({2'b10, 24'h0});
      fab.reconfig();
      bad <= 1'b1;
      repeat (12) @(posedge clock);
      bad <= 1'b0;
      rd(SEL_PREV1, r);
      `CHECK("prev1_bad", {1'b0, 5'b00100, MODE_APP, a2, BOOT_LOW_BITS}, r);
      rd(SEL_PREV2, r);
      `CHECK("prev2_wd", {1'b0, 5'b00010, MODE_APP, a2, BOOT_LOW_BITS}, r);
      // crc is ignored in factory, an external reset reloads the factory image
      notes.push_back({2'b10, 24'h0});
      crc <= 1'b1;
      ext_rst <= 1'b1;
      repeat (12) @(posedge clock);
      `CHECK("ext_factory", MODE_FACTORY, master_state);
      `CHECK("notes_left", 0, notes.size());
      stop_test();
   end
endmodule
`default_nettype wire
